// >>> rtl/mies_cfg.svh
// register offsets, field positions and constants of the execution subset
`ifndef MIES_CFG_SVH
`define MIES_CFG_SVH
`define MIES_OFS_EXEC    8'h00
`define MIES_OFS_ACC     8'h04
`define MIES_OFS_FLAGS   8'h08
`define MIES_OFS_PC      8'h0c
`define MIES_OFS_WDT     8'h10
`define MIES_OFS_STACK   8'h14
`define MIES_DMEM_SEL    2'b01
`define MIES_OP_MSB      4
`define MIES_OP_LSB      0
`define MIES_MA_MSB      11
`define MIES_MA_LSB      8
`define MIES_IMM_MSB     23
`define MIES_IMM_LSB     16
`define MIES_TGT_LSB     16
`define MIES_FL_Z        0
`define MIES_FL_AC       1
`define MIES_FL_C        2
`define MIES_FL_TO       3
`define MIES_FL_PDF      4
`define MIES_FL_EMI      5
`define MIES_FL_PEND     6
`define MIES_FL_SLEEP    7
`define MIES_ACC_RST     8'h00
`define MIES_CMD_RST     32'h0000_0000
`define MIES_BCD_MAX     4'h9
`define MIES_BCD_ADJ     4'h6
`define MIES_ONE         8'h01
`define MIES_ALL_ONES    8'hff
`endif

// >>> rtl/mies_core.sv
// execution core for a subset of an 8-bit controller instruction set
`include "mies_cfg.svh"

// Behaviour
// - watchdog kick clears counter, prescaler, expired and power-down flags.
// - paired kicks act only when alternated; repeats change nothing.
// - invert in place writes complement back; only zero flag changes.
// - invert to working loads complement; memory unchanged; only zero flag.
// - decimal adjust adds 6 to low nibble if above 9 or nibble wrap.
// - adds 6 to high nibble if above 9 or wrap; result to memory.
// - decimal adjust changes only wrap flag, marking sum above 99.
// - decrement to memory or working register; only zero flag changes.
// - increment to memory or working register; only zero flag changes.
// - power down halts, keeps data, clears watchdog, sets sleep flag.
// - branch loads program counter from instruction, two cycles, no flags.
// - move forms load or store working register, no flags.
// - no operation changes nothing and proceeds to next instruction.
// - or forms to working register or memory; only zero flag changes.
// - return pops program counter from stack, no flags.
// - return with immediate also loads working register, no flags.
// - interrupt exit pops program counter and sets global enable.
// - pending interrupt at interrupt exit is serviced before returning.
// - rotate left in memory, bit 7 into bit 0, no flags.
// - rotate left to working register, memory unchanged.
module mies_core #(
	parameter int             PC_W      = 11,
	parameter int             STK_DEPTH = 8,
	parameter int             DM_DEPTH  = 16,
	parameter int             WDT_W     = 8,
	parameter int             PRE_W     = 4,
	parameter logic [PC_W-1:0] IRQ_VEC  = 11'h004
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// core state
	output logic             halted
);
	localparam int SP_W = $clog2(STK_DEPTH);
	localparam int DA_W = $clog2(DM_DEPTH);

	logic [31:0]              readdata_r;
	logic [31:0]              rd_nxt;
	logic                     waitrequest_r;
	logic                     busy_r;
	logic [31:0]              cmd_r;
	logic [7:0]               acc_r;
	logic [PC_W-1:0]          pc_r;
	logic [SP_W-1:0]          sp_r;
	logic [PC_W-1:0]          stk [STK_DEPTH];
	logic [7:0]               dmem [DM_DEPTH];
	logic [WDT_W-1:0]         wdt_r;
	logic [PRE_W-1:0]         pre_r;
	logic                     z_r, ac_r, c_r, to_r, pdf_r, emi_r;
	logic                     pend_r, sleep_r;
	mies_pkg::mies_kick_type  kick_r;
	mies_pkg::mies_op_type    op;
	mies_pkg::mies_res_type   res;
	logic                     accept, bus_wr, exec_go, dm_hit, pair_ok;
	logic [DA_W-1:0]          ex_addr, bus_idx;
	logic [7:0]               mval, ex_imm;
	logic [PC_W-1:0]          ex_tgt, stk_top;
	logic [8:0]               bcd_sum;
	logic                     lo_adj, hi_adj;
	logic [7:0]               fl;

	assign readdata    = readdata_r;
	assign waitrequest = waitrequest_r;
	assign halted      = sleep_r;

	// a request is taken once, on the first edge it is seen while idle
	assign accept  = (read | write) & waitrequest_r & ~busy_r;
	assign bus_wr  = accept & write;
	// the system clock is off while asleep, so commands are answered only
	assign exec_go = bus_wr & (address == `MIES_OFS_EXEC) & ~sleep_r;
	assign op      = mies_pkg::mies_op_type'(
		writedata[`MIES_OP_MSB:`MIES_OP_LSB]);
	assign ex_addr = DA_W'(writedata[`MIES_MA_MSB:`MIES_MA_LSB]);
	assign ex_imm  = writedata[`MIES_IMM_MSB:`MIES_IMM_LSB];
	assign ex_tgt  = writedata[`MIES_TGT_LSB+PC_W-1:`MIES_TGT_LSB];
	assign mval    = dmem[ex_addr];
	assign stk_top = stk[sp_r - 1'b1];
	assign dm_hit  = (address[7:6] == `MIES_DMEM_SEL);
	assign bus_idx = DA_W'(address[5:2]);
	// alternation: the other half of the pair was the last one seen
	assign pair_ok = (op == mies_pkg::OP_KICK1 &&
		kick_r == mies_pkg::KICK_SECOND) | (op == mies_pkg::OP_KICK2 &&
		kick_r == mies_pkg::KICK_FIRST);

	// decimal adjust nibble tests
	assign lo_adj  = (acc_r[3:0] > `MIES_BCD_MAX) | ac_r;
	assign hi_adj  = (acc_r[7:4] > `MIES_BCD_MAX) | c_r;
	assign bcd_sum = {1'b0, acc_r} +
		{1'b0, (hi_adj ? `MIES_BCD_ADJ : 4'h0),
		(lo_adj ? `MIES_BCD_ADJ : 4'h0)};

	always_comb begin
		res         = '0;
		res.acc     = acc_r;
		res.mem     = mval;
		case (op)
			mies_pkg::OP_KICK, mies_pkg::OP_KICK1, mies_pkg::OP_KICK2: begin
				res.kick = 1'b1;
			end
			mies_pkg::OP_INV, mies_pkg::OP_INVA: begin
				res.wr_mem = (op == mies_pkg::OP_INV);
				res.wr_acc = (op == mies_pkg::OP_INVA);
				res.mem    = ~mval;
				res.acc    = ~mval;
				res.upd_z  = 1'b1;
			end
			mies_pkg::OP_DAA: begin
				res.wr_mem = 1'b1;
				res.mem    = bcd_sum[7:0];
				res.upd_c  = 1'b1;
				res.c      = hi_adj | bcd_sum[8];
			end
			mies_pkg::OP_DEC, mies_pkg::OP_MINUS_ONE_TO_WORKING: begin
				res.wr_mem = (op == mies_pkg::OP_DEC);
				res.wr_acc = (op == mies_pkg::OP_MINUS_ONE_TO_WORKING);
				res.mem    = mval - `MIES_ONE;
				res.acc    = mval - `MIES_ONE;
				res.upd_z  = 1'b1;
			end
			mies_pkg::OP_INC, mies_pkg::OP_PLUS_ONE_TO_WORKING: begin
				res.wr_mem = (op == mies_pkg::OP_INC);
				res.wr_acc = (op == mies_pkg::OP_PLUS_ONE_TO_WORKING);
				res.mem    = mval + `MIES_ONE;
				res.acc    = mval + `MIES_ONE;
				res.upd_z  = 1'b1;
			end
			mies_pkg::OP_HALT: res.halt = 1'b1;
			mies_pkg::OP_JMP: begin
				res.load_pc = 1'b1;
				res.two     = 1'b1;
			end
			mies_pkg::OP_MOV_AM, mies_pkg::OP_MOV_AX: begin
				res.wr_acc = 1'b1;
				res.acc    = (op == mies_pkg::OP_MOV_AX) ? ex_imm : mval;
			end
			mies_pkg::OP_MOV_MA: begin
				res.wr_mem = 1'b1;
				res.mem    = acc_r;
			end
			mies_pkg::OP_OR_AM, mies_pkg::OP_OR_AX: begin
				res.wr_acc = 1'b1;
				res.acc    = acc_r | ((op == mies_pkg::OP_OR_AX) ?
					ex_imm : mval);
				res.upd_z  = 1'b1;
			end
			mies_pkg::OP_ORM: begin
				res.wr_mem = 1'b1;
				res.mem    = acc_r | mval;
				res.upd_z  = 1'b1;
			end
			mies_pkg::OP_RET, mies_pkg::OP_RETAX, mies_pkg::OP_INTERRUPT_EXIT: begin
				res.load_pc = 1'b1;
				res.pop     = 1'b1;
				res.two     = 1'b1;
				res.wr_acc  = (op == mies_pkg::OP_RETAX);
				res.acc     = ex_imm;
				res.interrupt_exit    = (op == mies_pkg::OP_INTERRUPT_EXIT);
			end
			mies_pkg::OP_RL, mies_pkg::OP_RLA: begin
				res.wr_mem = (op == mies_pkg::OP_RL);
				res.wr_acc = (op == mies_pkg::OP_RLA);
				res.mem    = {mval[6:0], mval[7]};
				res.acc    = {mval[6:0], mval[7]};
			end
			default: res.two = 1'b0;
		endcase
		res.z = res.wr_acc ? (res.acc == 8'h00) : (res.mem == 8'h00);
	end

	// bus handshake: one wait cycle, one more for program counter loads
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			waitrequest_r <= 1'b1;
			busy_r        <= 1'b0;
			readdata_r    <= 32'h0000_0000;
		end else if (!waitrequest_r) begin
			waitrequest_r <= 1'b1;
		end else if (busy_r) begin
			busy_r        <= 1'b0;
			waitrequest_r <= 1'b0;
		end else if (accept) begin
			readdata_r <= rd_nxt;
			if (exec_go && res.two)
				busy_r <= 1'b1;
			else
				waitrequest_r <= 1'b0;
		end
	end

	always_comb begin
		fl                = 8'h00;
		fl[`MIES_FL_Z]     = z_r;
		fl[`MIES_FL_AC]    = ac_r;
		fl[`MIES_FL_C]     = c_r;
		fl[`MIES_FL_TO]    = to_r;
		fl[`MIES_FL_PDF]   = pdf_r;
		fl[`MIES_FL_EMI]   = emi_r;
		fl[`MIES_FL_PEND]  = pend_r;
		fl[`MIES_FL_SLEEP] = sleep_r;
		if (write)
			rd_nxt = 32'h0000_0000;
		else if (dm_hit)
			rd_nxt = {24'h000000, dmem[bus_idx]};
		else
			case (address)
				`MIES_OFS_EXEC:  rd_nxt = cmd_r;
				`MIES_OFS_ACC:   rd_nxt = {24'h000000, acc_r};
				`MIES_OFS_FLAGS: rd_nxt = {24'h000000, fl};
				`MIES_OFS_PC:    rd_nxt = 32'(pc_r);
				`MIES_OFS_WDT:   rd_nxt = 32'(wdt_r);
				`MIES_OFS_STACK: rd_nxt = 32'(sp_r);
				default:         rd_nxt = 32'h0000_0000;
			endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			cmd_r <= `MIES_CMD_RST;
		else if (exec_go)
			cmd_r <= writedata;
	end

	// working register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			acc_r <= `MIES_ACC_RST;
		else if (exec_go && res.wr_acc)
			acc_r <= res.acc;
		else if (bus_wr && address == `MIES_OFS_ACC)
			acc_r <= writedata[7:0];
	end

	// data memory: not reset, contents survive power down
	always_ff @(posedge mclk) begin
		if (exec_go && res.wr_mem)
			dmem[ex_addr] <= res.mem;
		else if (bus_wr && dm_hit)
			dmem[bus_idx] <= writedata[7:0];
	end

	// program counter and stack
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pc_r <= '0;
			sp_r <= '0;
		end else if (exec_go) begin
			if (res.interrupt_exit && pend_r) begin
				// popped address stays on the stack as the handler's return
				pc_r <= IRQ_VEC;
			end else if (res.pop) begin
				pc_r <= stk_top;
				sp_r <= sp_r - 1'b1;
			end else if (res.load_pc) begin
				pc_r <= ex_tgt;
			end else begin
				pc_r <= pc_r + 1'b1;
			end
		end else if (bus_wr && address == `MIES_OFS_PC) begin
			pc_r <= writedata[PC_W-1:0];
		end else if (bus_wr && address == `MIES_OFS_STACK) begin
			// overflow wraps and overwrites the oldest entry
			stk[sp_r] <= writedata[PC_W-1:0];
			sp_r      <= sp_r + 1'b1;
		end
	end

	// flags, power down and kick pairing
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{z_r, ac_r, c_r, to_r, pdf_r, emi_r, pend_r, sleep_r} <= 8'h00;
			kick_r  <= mies_pkg::KICK_NONE;
		end else if (exec_go) begin
			if (res.upd_z)
				z_r <= res.z;
			if (res.upd_c)
				c_r <= res.c;
			if (op == mies_pkg::OP_KICK || pair_ok) begin
				to_r  <= 1'b0;
				pdf_r <= 1'b0;
			end
			// a completed pair re-arms, so the next pair starts afresh
			if (op == mies_pkg::OP_KICK1 || op == mies_pkg::OP_KICK2)
				kick_r <= pair_ok ? mies_pkg::KICK_NONE :
					(op == mies_pkg::OP_KICK1 ? mies_pkg::KICK_FIRST
					: mies_pkg::KICK_SECOND);
			if (res.halt) begin
				to_r    <= 1'b0;
				pdf_r   <= 1'b1;
				sleep_r <= 1'b1;
			end
			if (res.interrupt_exit) begin
				// entering the pending handler masks again
				emi_r  <= ~pend_r;
				pend_r <= 1'b0;
			end
		end else if (bus_wr && address == `MIES_OFS_FLAGS) begin
			z_r     <= writedata[`MIES_FL_Z];
			ac_r    <= writedata[`MIES_FL_AC];
			c_r     <= writedata[`MIES_FL_C];
			to_r    <= writedata[`MIES_FL_TO];
			pdf_r   <= writedata[`MIES_FL_PDF];
			emi_r   <= writedata[`MIES_FL_EMI];
			pend_r  <= writedata[`MIES_FL_PEND];
			sleep_r <= 1'b0; // any flags write is the wake event
		end
	end

	wire wd_clr = exec_go & (res.halt | (op == mies_pkg::OP_KICK) |
		pair_ok);

	// watchdog counter and prescaler; time-out handling lives elsewhere
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wdt_r <= '0;
			pre_r <= '0;
		end else if (wd_clr) begin
			wdt_r <= '0;
			pre_r <= '0;
		end else if (!sleep_r) begin
			pre_r <= pre_r + 1'b1;
			if (&pre_r)
				wdt_r <= wdt_r + 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_kick_clear: assert property (exec_go && op == mies_pkg::OP_KICK
		|=> wdt_r == '0 && !to_r && !pdf_r) else $error("kick failed");
	a_kick_repeat: assert property (exec_go && op == mies_pkg::OP_KICK1
		&& kick_r != mies_pkg::KICK_SECOND |=> $stable(to_r)
		&& $stable(pdf_r)) else $error("repeated kick acted");
	a_kick_pair: assert property (exec_go && op == mies_pkg::OP_KICK2
		&& kick_r == mies_pkg::KICK_FIRST |=> wdt_r == '0 && !to_r
		&& !pdf_r) else $error("alternated kick ignored");
	a_inv_mem: assert property (exec_go && op == mies_pkg::OP_INV
		|=> dmem[$past(ex_addr)] == ~$past(mval) && $stable(c_r)
		&& z_r == ($past(mval) == `MIES_ALL_ONES)) else $error("invert bad");
	a_inv_acc: assert property (exec_go && op == mies_pkg::OP_INVA
		|=> acc_r == ~$past(mval) && dmem[$past(ex_addr)] == $past(mval))
		else $error("invert to working bad");
	a_daa_low: assert property (exec_go && op == mies_pkg::OP_DAA
		&& acc_r == 8'h1a && !c_r |=> dmem[$past(ex_addr)] == 8'h20)
		else $error("low nibble adjust bad");
	a_daa_wrap: assert property (exec_go && op == mies_pkg::OP_DAA
		&& acc_r == 8'ha0 && !ac_r |=> dmem[$past(ex_addr)] == 8'h00
		&& c_r && $stable(z_r)) else $error("high nibble adjust bad");
	a_dec_mem: assert property (exec_go && op == mies_pkg::OP_DEC
		|=> dmem[$past(ex_addr)] == $past(mval) - `MIES_ONE)
		else $error("decrement bad");
	a_inc_acc: assert property (exec_go && op == mies_pkg::OP_PLUS_ONE_TO_WORKING
		|=> acc_r == $past(mval) + `MIES_ONE) else $error("increment bad");
	a_halt_sleep: assert property (exec_go && op == mies_pkg::OP_HALT
		|=> sleep_r && pdf_r && !to_r && wdt_r == '0 && pre_r == '0)
		else $error("power down bad");
	a_jmp_timing: assert property (exec_go && op == mies_pkg::OP_JMP
		|=> pc_r == $past(ex_tgt) && busy_r ##1 !waitrequest_r)
		else $error("branch bad");
	a_one_cycle: assert property (exec_go && !res.two
		|=> !waitrequest_r) else $error("single cycle late");
	a_mov_imm: assert property (exec_go && op == mies_pkg::OP_MOV_AX
		|=> acc_r == $past(ex_imm) && $stable(z_r)) else $error("move bad");
	a_nop_next: assert property (exec_go && op == mies_pkg::OP_IDLE
		|=> pc_r == $past(pc_r) + 1'b1 && $stable(acc_r))
		else $error("idle bad");
	a_or_acc: assert property (exec_go && op == mies_pkg::OP_OR_AX
		|=> acc_r == ($past(acc_r) | $past(ex_imm))) else $error("or bad");
	a_ret_pop: assert property (exec_go && op == mies_pkg::OP_RETAX
		|=> pc_r == $past(stk_top) && acc_r == $past(ex_imm))
		else $error("return bad");
	a_interrupt_exit_emi: assert property (exec_go && op == mies_pkg::OP_INTERRUPT_EXIT
		&& !pend_r |=> emi_r && pc_r == $past(stk_top))
		else $error("interrupt exit bad");
	a_interrupt_exit_pend: assert property (exec_go && op == mies_pkg::OP_INTERRUPT_EXIT
		&& pend_r |=> pc_r == IRQ_VEC && !pend_r) else $error("pending lost");
	a_rl_mem: assert property (exec_go && op == mies_pkg::OP_RL
		|=> dmem[$past(ex_addr)] == {$past(mval[6:0]), $past(mval[7])})
		else $error("rotate bad");
	a_rla_acc: assert property (exec_go && op == mies_pkg::OP_RLA
		|=> acc_r == {$past(mval[6:0]), $past(mval[7])})
		else $error("rotate to working bad");

	c_kick_pair: cover property (exec_go && op == mies_pkg::OP_KICK2
		&& kick_r == mies_pkg::KICK_FIRST);
	c_daa_carry: cover property (exec_go && op == mies_pkg::OP_DAA
		&& bcd_sum[8]);
	c_interrupt_exit_pend: cover property (exec_go && op == mies_pkg::OP_INTERRUPT_EXIT
		&& pend_r);
	c_halt: cover property (exec_go && op == mies_pkg::OP_HALT);
endmodule // mies_core

// >>> rtl/mies_pkg.sv
// types shared by the instruction execution subset
package mies_pkg;
	typedef enum logic [4:0] {
		OP_IDLE, OP_KICK, OP_KICK1, OP_KICK2, OP_INV, OP_INVA, OP_DAA,
		OP_DEC, OP_MINUS_ONE_TO_WORKING, OP_INC, OP_PLUS_ONE_TO_WORKING, OP_HALT, OP_JMP, OP_MOV_AM,
		OP_MOV_AX, OP_MOV_MA, OP_OR_AM, OP_OR_AX, OP_ORM, OP_RET,
		OP_RETAX, OP_INTERRUPT_EXIT, OP_RL, OP_RLA
	} mies_op_type;

	typedef enum logic [1:0] {KICK_NONE, KICK_FIRST, KICK_SECOND}
		mies_kick_type;

	typedef struct packed {
		logic       wr_acc;
		logic [7:0] acc;
		logic       wr_mem;
		logic [7:0] mem;
		logic       upd_z;
		logic       z;
		logic       upd_c;
		logic       c;
		logic       kick;
		logic       halt;
		logic       load_pc;
		logic       pop;
		logic       interrupt_exit;
		logic       two;
	} mies_res_type;
endpackage : mies_pkg

// >>> verification/mies_host.sv
// avalon-mm master standing in for the software side of the core
module mies_host (
	// clock
	input  wire logic        mclk,
	// avalon-mm master
	output logic      [7:0]  address,
	output logic             read,
	output logic             write,
	output logic      [31:0] writedata,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		address   = 8'h00;
		read      = 1'b0;
		write     = 1'b0;
		writedata = 32'h0000_0000;
	end

	// request held until waitrequest is sampled low; waits counts the
	// edges that saw waitrequest high; a hung slave is ended by the
	// bench watchdog, not here
	task automatic xfer(input logic rd_en, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output int waits);
		int n;
		n = 0;
		@(posedge mclk);
		address   <= a;
		writedata <= d;
		read      <= rd_en;
		write     <= ~rd_en;
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0);
		q = readdata;
		waits = n - 1;
		read      <= 1'b0;
		write     <= 1'b0;
		// released lines show the inverse so stale values are not trusted
		address   <= ~a;
		writedata <= ~d;
	endtask
endmodule // mies_host

// >>> verification/tb_top.sv
// self-checking bench for the instruction execution subset
`include "mies_cfg.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [10:0] IRQ_PC = 11'h004;

	logic        mclk;
	logic        rst;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        halted;
	logic [31:0] q;
	int          w;
	int          err_total;
	int          n_compared;

	mies_core #(.IRQ_VEC(IRQ_PC)) dut (
		.mclk(mclk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .halted(halted)
	);

	mies_host host (
		.mclk(mclk), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest)
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b0, a, d, q, w);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		host.xfer(1'b1, a, 32'h0, q, w);
		chk(q, e);
	endtask

	function automatic logic [7:0] mem_a(input logic [3:0] i);
		return {`MIES_DMEM_SEL, i, 2'b00};
	endfunction

	task automatic ex(input mies_pkg::mies_op_type op,
		input logic [3:0] ma, input logic [10:0] t);
		logic [31:0] d;
		d = 32'h0;
		d[4:0] = op;
		d[11:8] = ma;
		d[26:16] = t;
		host.xfer(1'b0, `MIES_OFS_EXEC, d, q, w);
	endtask

	// one data operation from flags 6 (zero clear): destination,
	// untouched operand, flags and single-cycle answer
	task automatic row(input mies_pkg::mies_op_type op,
		input logic [7:0] a, m, x, e, input logic da, zu);
		wr(mem_a(4'h5), {24'h0, m});
		wr(`MIES_OFS_ACC, {24'h0, a});
		wr(`MIES_OFS_FLAGS, 32'h6);
		ex(op, 4'h5, {3'h0, x});
		chk(32'(w), 32'h1);
		rd(da ? `MIES_OFS_ACC : mem_a(4'h5), {24'h0, e});
		rd(da ? mem_a(4'h5) : `MIES_OFS_ACC, {24'h0, da ? m : a});
		rd(`MIES_OFS_FLAGS, {29'h0, 2'b11, zu & (e == 8'h00)});
	endtask

	task automatic daa(input logic [7:0] a, input logic ac, c);
		logic [8:0] s;
		logic       hi;
		hi = (a[7:4] > 4'h9) || c;
		s = {1'b0, a} + {1'b0, hi ? 4'h6 : 4'h0,
			(a[3:0] > 4'h9 || ac) ? 4'h6 : 4'h0};
		wr(`MIES_OFS_ACC, {24'h0, a});
		wr(`MIES_OFS_FLAGS, {29'h0, c, ac, 1'b1});
		ex(mies_pkg::OP_DAA, 4'h6, 11'h000);
		rd(mem_a(4'h6), {24'h0, s[7:0]});
		rd(`MIES_OFS_FLAGS, {29'h0, hi | s[8], ac, 1'b1});
	endtask

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// whole sequence needs well under 5000 cycles
	initial begin
		#200000;
		err_total++;
		test_done();
	end

	initial begin
		err_total  = 0;
		n_compared = 0;
		rst = 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		chk({31'h0, halted}, 32'h0);
		rd(`MIES_OFS_ACC, 32'h0);
		rd(`MIES_OFS_PC, 32'h0);
		wr(8'h30, 32'hffff_ffff);
		rd(8'h30, 32'h0);
		// repeated first kick must leave counter and flags alone
		repeat (40) @(posedge mclk);
		wr(`MIES_OFS_FLAGS, 32'h18);
		ex(mies_pkg::OP_KICK1, 4'h0, 11'h000);
		ex(mies_pkg::OP_KICK1, 4'h0, 11'h000);
		host.xfer(1'b1, `MIES_OFS_WDT, 32'h0, q, w);
		chk({31'h0, q[7:0] !== 8'h00}, 32'h1);
		rd(`MIES_OFS_FLAGS, 32'h18);
		ex(mies_pkg::OP_KICK2, 4'h0, 11'h000);
		rd(`MIES_OFS_FLAGS, 32'h0);
		rd(`MIES_OFS_WDT, 32'h0);
		wr(`MIES_OFS_FLAGS, 32'h18);
		ex(mies_pkg::OP_KICK2, 4'h0, 11'h000);
		rd(`MIES_OFS_FLAGS, 32'h18);
		ex(mies_pkg::OP_KICK1, 4'h0, 11'h000);
		rd(`MIES_OFS_FLAGS, 32'h0);
		wr(`MIES_OFS_FLAGS, 32'h18);
		repeat (40) @(posedge mclk);
		ex(mies_pkg::OP_KICK, 4'h0, 11'h000);
		rd(`MIES_OFS_FLAGS, 32'h0);
		rd(`MIES_OFS_WDT, 32'h0);
		row(mies_pkg::OP_INV, 8'h3c, 8'h5a, 8'h00, 8'ha5, 0, 1);
		row(mies_pkg::OP_INVA, 8'h3c, 8'hff, 8'h00, 8'h00, 1, 1);
		row(mies_pkg::OP_DEC, 8'h3c, 8'h01, 8'h00, 8'h00, 0, 1);
		row(mies_pkg::OP_MINUS_ONE_TO_WORKING, 8'h3c, 8'h00, 8'h00, 8'hff, 1, 1);
		row(mies_pkg::OP_INC, 8'h3c, 8'hff, 8'h00, 8'h00, 0, 1);
		row(mies_pkg::OP_PLUS_ONE_TO_WORKING, 8'h3c, 8'h7f, 8'h00, 8'h80, 1, 1);
		row(mies_pkg::OP_MOV_AM, 8'h3c, 8'h00, 8'h00, 8'h00, 1, 0);
		row(mies_pkg::OP_MOV_AX, 8'h3c, 8'h11, 8'h00, 8'h00, 1, 0);
		row(mies_pkg::OP_MOV_MA, 8'h00, 8'h11, 8'h00, 8'h00, 0, 0);
		row(mies_pkg::OP_OR_AM, 8'h00, 8'h00, 8'h00, 8'h00, 1, 1);
		row(mies_pkg::OP_OR_AX, 8'h30, 8'h11, 8'h03, 8'h33, 1, 1);
		row(mies_pkg::OP_ORM, 8'h00, 8'h00, 8'h00, 8'h00, 0, 1);
		row(mies_pkg::OP_RL, 8'h3c, 8'h81, 8'h00, 8'h03, 0, 0);
		row(mies_pkg::OP_RLA, 8'h3c, 8'h40, 8'h00, 8'h80, 1, 0);
		daa(8'h12, 1'b0, 1'b0);
		daa(8'h1a, 1'b0, 1'b0);
		daa(8'h15, 1'b1, 1'b0);
		daa(8'ha0, 1'b0, 1'b0);
		daa(8'h31, 1'b0, 1'b1);
		daa(8'hcd, 1'b0, 1'b0);
		wr(`MIES_OFS_PC, 32'h10);
		wr(`MIES_OFS_FLAGS, 32'h7);
		wr(`MIES_OFS_ACC, 32'h99);
		ex(mies_pkg::OP_IDLE, 4'h0, 11'h000);
		chk(32'(w), 32'h1);
		rd(`MIES_OFS_PC, 32'h11);
		rd(`MIES_OFS_FLAGS, 32'h7);
		rd(`MIES_OFS_ACC, 32'h99);
		ex(mies_pkg::OP_JMP, 4'h0, 11'h123);
		chk(32'(w), 32'h2);
		rd(`MIES_OFS_PC, 32'h123);
		rd(`MIES_OFS_FLAGS, 32'h7);
		rd(`MIES_OFS_EXEC, 32'h0123_000c);
		wr(`MIES_OFS_STACK, 32'h55);
		rd(`MIES_OFS_STACK, 32'h1);
		ex(mies_pkg::OP_RET, 4'h0, 11'h000);
		chk(32'(w), 32'h2);
		rd(`MIES_OFS_PC, 32'h55);
		rd(`MIES_OFS_STACK, 32'h0);
		wr(`MIES_OFS_STACK, 32'h2aa);
		ex(mies_pkg::OP_RETAX, 4'h0, 11'h0c3);
		rd(`MIES_OFS_PC, 32'h2aa);
		rd(`MIES_OFS_ACC, 32'hc3);
		rd(`MIES_OFS_FLAGS, 32'h7);
		// pending request diverts to the handler, return stays stacked
		wr(`MIES_OFS_STACK, 32'h77);
		wr(`MIES_OFS_FLAGS, 32'h40);
		ex(mies_pkg::OP_INTERRUPT_EXIT, 4'h0, 11'h000);
		chk(32'(w), 32'h2);
		rd(`MIES_OFS_PC, {21'h0, IRQ_PC});
		rd(`MIES_OFS_FLAGS, 32'h0);
		rd(`MIES_OFS_STACK, 32'h1);
		ex(mies_pkg::OP_INTERRUPT_EXIT, 4'h0, 11'h000);
		rd(`MIES_OFS_PC, 32'h77);
		rd(`MIES_OFS_FLAGS, 32'h20);
		wr(`MIES_OFS_FLAGS, 32'h8);
		wr(`MIES_OFS_ACC, 32'h5e);
		repeat (40) @(posedge mclk);
		ex(mies_pkg::OP_HALT, 4'h0, 11'h000);
		chk({31'h0, halted}, 32'h1);
		rd(`MIES_OFS_FLAGS, 32'h90);
		rd(`MIES_OFS_WDT, 32'h0);
		ex(mies_pkg::OP_MOV_AX, 4'h0, 11'h011);
		rd(`MIES_OFS_ACC, 32'h5e);
		wr(`MIES_OFS_FLAGS, 32'h0);
		chk({31'h0, halted}, 32'h0);
		test_done();
	end
endmodule // tb_top
